// file: hw/spi_status_pkg.sv
package spi_status_pkg;

  // ----------------------------------------------------------------
  // Opcodes handled here
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_READ_OTP     = 8'h77;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int ST_LOCK  = 7;
  localparam int ST_RSVD  = 6;
  localparam int ST_ERR   = 5;
  localparam int ST_WPP   = 4;
  localparam int ST_SWP_H = 3;
  localparam int ST_SWP_L = 2;
  localparam int ST_WEL   = 1;
  localparam int ST_BUSY  = 0;

  localparam logic       RSVD_VALUE = 1'b0;
  localparam logic [1:0] SWP_NONE   = 2'h0;
  localparam logic [1:0] SWP_SOME   = 2'h1;
  localparam logic [1:0] SWP_ALL    = 2'h3;

  // Global protect field inside the write-status data byte
  localparam int WSR_GLOB_H = 5;
  localparam int WSR_GLOB_L = 2;

  // ----------------------------------------------------------------
  // Frame layout and security area
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] BIT_FIRST  = 3'h0;
  localparam logic [1:0] ADDR_LAST  = 2'h2;
  localparam logic [1:0] DUMMY_LAST = 2'h1;
  localparam int         OTP_AW     = 7;
  localparam int         OTP_DEPTH  = 128;

  // ----------------------------------------------------------------
  // Link phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_OTP_OUT,
    PH_STAT_OUT,
    PH_WSR_DATA,
    PH_IGNORE
  } link_phase_e;

endpackage

// file: hw/spi_status_otp.sv
`timescale 1ns/1ps
// Contract
// - Security read is 77h, three address bytes, two dummy bytes, then data out.
// - Security read streams bytes and wraps from 7Fh to 00h without pause.
// - Chip select rising ends a security read and floats the output at once.
// - After 05h status shifts out MSB first, repeating from bit 7 after bit 0.
// - Every repeated status byte carries freshly sampled flags.
// - Status read is answered at any time, also during busy.
// - Chip select rising ends a status read and floats the output at once.
// - Write-status changes only the lock bit; other status bits are read-only.
// - With lock set, protect and unprotect are ignored, global protect refused.
// - Lock powers up 0; the reset operation leaves it unchanged.
// - With protect pin asserted lock may only go from 0 to 1.
// - Error flag set when a byte fails, refreshed after each operation.
// - Error flag is not set by an aborted program or erase.
// - Bit 4 is 0 while protect pin is asserted, 1 while deasserted.
// - Bits 3:2 give none 00, some 01, all 11 of sectors protected.
// - With write-enable clear, program, erase, protect and write-status are rejected.
// - Write-enable latch clears at power-up and on the reset operation; a write-enable ending in the same cycle sets it instead.
// - Latch clears on write-disable and after any write-type command or hold abort; a write-enable ending in the same cycle as the abort sets it.
// - Incomplete or unknown opcode leaves the latch set.
// - Bit 0 is 1 while busy; host polls until it falls.
// - Host sets the latch with write-enable before any write-type command.
// - Write-status is 01h plus a byte, bit 7 new lock, latch clears at end.
module spi_status_otp
  import spi_status_pkg::*;
#(
  parameter int                       NUM_SECTORS = 4,
  parameter logic [7:0]               WREN_OPCODE = 8'h06,
  parameter logic [7:0]               WRDI_OPCODE = 8'h04,
  parameter logic [7:0]               PROT_OPCODE = 8'h36,
  parameter logic [7:0]               UNPR_OPCODE = 8'h39,
  parameter int                       NUM_WR_OPS  = 8,
  parameter logic [NUM_WR_OPS*8-1:0]  WRITE_OPS   = 64'h9b_02_20_52_d8_60_c7_36,
  parameter logic [OTP_DEPTH*8-1:0]   OTP_INIT    = '1
) (
  // System clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Serial link
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic                   si,
  output logic                        so_out,
  output logic                        so_oe_n,
  // Device pins and core state
  input  wire logic                   wp_n,
  input  wire logic                   op_busy,
  input  wire logic                   op_done,
  input  wire logic                   op_fail,
  input  wire logic                   reset_op,
  input  wire logic                   hold_abort,
  input  wire logic [NUM_SECTORS-1:0] sector_prot,
  // Commands toward the core
  output logic                        cmd_valid,
  output logic [7:0]                  cmd_opcode,
  output logic                        glob_valid,
  output logic [3:0]                  glob_bits,
  output logic [7:0]                  status_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    link_phase_e       phase;
    logic [2:0]        bit_cnt;
    logic [1:0]        byte_cnt;
    logic [7:0]        shift;
    logic [7:0]        opcode;
    logic              op_full;
    logic [7:0]        wsr_data;
    logic              wsr_full;
    logic [OTP_AW-1:0] addr;
    logic [7:0]        out_sh;
    logic              so;
    logic              drive;
    logic [7:0]        stat_m;
    logic [7:0]        stat_s;
  } link_s;

  typedef struct packed {
    logic       cs_m;
    logic       cs_1;
    logic       cs_2;
    logic       cs_lvl;
    logic       wp_m;
    logic       wp_1;
    logic       wp_2;
    logic       wp_lvl;
    logic       lock;
    logic       write_enable_latch;
    logic       err;
    logic       cmd_valid;
    logic [7:0] cmd_opcode;
    logic       glob_valid;
    logic [3:0] glob_bits;
    logic [7:0] status;
  } sys_s;

  link_s link_q;
  link_s link_d;
  sys_s  sys_q;
  sys_s  sys_d;
  logic  fresh_q;

  // ----------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------
  logic [NUM_WR_OPS-1:0] wr_hit;
  logic                  is_write_op;
  logic                  is_prot_op;

  for (genvar g = 0; g < NUM_WR_OPS; g++) begin : g_wr
    assign wr_hit[g] = (link_q.opcode == WRITE_OPS[g*8 +: 8]);
  end

  assign is_write_op = |wr_hit;
  assign is_prot_op  = (link_q.opcode == PROT_OPCODE) || (link_q.opcode == UNPR_OPCODE);

  // ----------------------------------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------------------------------
  // Raised chip select marks the next edge as the first of a frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_comb begin
    link_s       cur;
    logic [7:0]  in_byte;
    logic        byte_done;
    logic        load;
    logic [7:0]  load_byte;
    cur       = link_q;
    in_byte   = 8'h00;
    byte_done = 1'b0;
    load      = 1'b0;
    load_byte = 8'h00;
    if (fresh_q) begin
      cur.phase    = PH_OPCODE;
      cur.bit_cnt  = BIT_FIRST;
      cur.byte_cnt = 2'h0;
      cur.op_full  = 1'b0;
      cur.wsr_full = 1'b0;
      cur.drive    = 1'b0;
    end
    link_d        = cur;
    in_byte       = {cur.shift[6:0], si};
    byte_done     = (cur.bit_cnt == BIT_LAST);
    link_d.shift  = in_byte;
    link_d.bit_cnt = cur.bit_cnt + 3'h1;
    link_d.stat_m = sys_q.status;
    link_d.stat_s = link_q.stat_m;
    unique case (cur.phase)
      PH_OPCODE: begin
        if (byte_done) begin
          link_d.opcode  = in_byte;
          link_d.op_full = 1'b1;
          if (in_byte == OP_READ_STATUS) begin
            link_d.phase = PH_STAT_OUT;
            load         = 1'b1;
            load_byte    = link_q.stat_s;
          end else if (in_byte == OP_READ_OTP) begin
            link_d.phase    = PH_ADDR;
            link_d.byte_cnt = 2'h0;
          end else if (in_byte == OP_WRITE_STATUS) begin
            link_d.phase = PH_WSR_DATA;
          end else begin
            link_d.phase = PH_IGNORE;
          end
        end
      end
      PH_ADDR: begin
        if (byte_done) begin
          link_d.byte_cnt = cur.byte_cnt + 2'h1;
          if (cur.byte_cnt == ADDR_LAST) begin
            link_d.addr     = in_byte[OTP_AW-1:0];
            link_d.byte_cnt = 2'h0;
            link_d.phase    = PH_DUMMY;
          end
        end
      end
      PH_DUMMY: begin
        if (byte_done) begin
          link_d.byte_cnt = cur.byte_cnt + 2'h1;
          if (cur.byte_cnt == DUMMY_LAST) begin
            link_d.phase = PH_OTP_OUT;
            load         = 1'b1;
            load_byte    = OTP_INIT[{cur.addr, 3'h0} +: 8];
            link_d.addr  = cur.addr + 1'b1;
          end
        end
      end
      PH_OTP_OUT: begin
        if (byte_done) begin
          load        = 1'b1;
          load_byte   = OTP_INIT[{cur.addr, 3'h0} +: 8];
          link_d.addr = cur.addr + 1'b1;
        end
      end
      PH_STAT_OUT: begin
        if (byte_done) begin
          load      = 1'b1;
          load_byte = link_q.stat_s;
        end
      end
      PH_WSR_DATA: begin
        if (byte_done) begin
          link_d.wsr_data = in_byte;
          link_d.wsr_full = 1'b1;
          link_d.phase    = PH_IGNORE;
        end
      end
      PH_IGNORE: begin
        link_d.phase = PH_IGNORE;
      end
    endcase
    if (load) begin
      link_d.drive  = 1'b1;
      link_d.so     = load_byte[7];
      link_d.out_sh = {load_byte[6:0], 1'b0};
    end else if (cur.drive) begin
      link_d.so     = cur.out_sh[7];
      link_d.out_sh = {cur.out_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= '{phase: PH_OPCODE, default: '0};
    end else begin
      link_q <= link_d;
    end
  end

  // Output floats as soon as chip select rises
  assign so_out  = link_q.so;
  assign so_oe_n = cs_n | fresh_q | ~link_q.drive;

  // ----------------------------------------------------------------
  // Status side, system clock domain
  // ----------------------------------------------------------------
  always_comb begin
    logic       cs_rise;
    logic       aligned;
    logic       wel_set;
    logic       wel_clr;
    logic [1:0] summary;
    logic       new_lock;
    cs_rise  = 1'b0;
    aligned  = 1'b0;
    wel_set  = 1'b0;
    wel_clr  = 1'b0;
    summary  = SWP_NONE;
    new_lock = 1'b0;
    sys_d    = sys_q;
    sys_d.cs_m = cs_n;
    sys_d.cs_1 = sys_q.cs_m;
    sys_d.cs_2 = sys_q.cs_1;
    if (sys_q.cs_1 == sys_q.cs_2) begin
      sys_d.cs_lvl = sys_q.cs_2;
    end
    sys_d.wp_m = wp_n;
    sys_d.wp_1 = sys_q.wp_m;
    sys_d.wp_2 = sys_q.wp_1;
    if (sys_q.wp_1 == sys_q.wp_2) begin
      sys_d.wp_lvl = sys_q.wp_2;
    end
    cs_rise          = !sys_q.cs_lvl && sys_q.cs_1 && sys_q.cs_2;
    aligned          = (link_q.bit_cnt == BIT_FIRST);
    new_lock         = link_q.wsr_data[ST_LOCK];
    sys_d.cmd_valid  = 1'b0;
    sys_d.glob_valid = 1'b0;
    // Frame fields stay still while chip select is high
    if (cs_rise && link_q.op_full) begin
      if (link_q.opcode == WREN_OPCODE) begin
        wel_set = aligned;
      end else if (link_q.opcode == WRDI_OPCODE) begin
        wel_clr = aligned;
      end else if (link_q.opcode == OP_WRITE_STATUS) begin
        wel_clr = 1'b1;
        if (sys_q.write_enable_latch && link_q.wsr_full && aligned) begin
          if (sys_q.wp_lvl || sys_q.lock == new_lock || new_lock) begin
            sys_d.lock = new_lock;
            if (!sys_q.lock) begin
              sys_d.glob_valid = 1'b1;
              sys_d.glob_bits  = link_q.wsr_data[WSR_GLOB_H:WSR_GLOB_L];
            end
          end
        end
      end else if (is_write_op) begin
        wel_clr = 1'b1;
        if (sys_q.write_enable_latch && aligned && !(sys_q.lock && is_prot_op)) begin
          sys_d.cmd_valid  = 1'b1;
          sys_d.cmd_opcode = link_q.opcode;
        end
      end
    end
    if (reset_op || hold_abort) begin
      wel_clr = 1'b1;
    end
    // Set wins over a clear in the same cycle
    if (wel_set) begin
      sys_d.write_enable_latch = 1'b1;
    end else if (wel_clr) begin
      sys_d.write_enable_latch = 1'b0;
    end
    // Aborts never pulse op_done, so they leave the flag alone
    if (op_done) begin
      sys_d.err = op_fail;
    end
    if (&sector_prot) begin
      summary = SWP_ALL;
    end else if (|sector_prot) begin
      summary = SWP_SOME;
    end else begin
      summary = SWP_NONE;
    end
    sys_d.status[ST_LOCK]           = sys_q.lock;
    sys_d.status[ST_RSVD]           = RSVD_VALUE;
    sys_d.status[ST_ERR]            = sys_q.err;
    sys_d.status[ST_WPP]            = sys_q.wp_lvl;
    sys_d.status[ST_SWP_H:ST_SWP_L] = summary;
    sys_d.status[ST_WEL]            = sys_q.write_enable_latch;
    sys_d.status[ST_BUSY]           = op_busy;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_q <= '{cs_m: 1'b1, cs_1: 1'b1, cs_2: 1'b1, cs_lvl: 1'b1,
                 wp_m: 1'b1, wp_1: 1'b1, wp_2: 1'b1, wp_lvl: 1'b1,
                 default: '0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign cmd_valid  = sys_q.cmd_valid;
  assign cmd_opcode = sys_q.cmd_opcode;
  assign glob_valid = sys_q.glob_valid;
  assign glob_bits  = sys_q.glob_bits;
  assign status_out = sys_q.status;

endmodule

// file: verification/spi_status_otp_sva.sv
`timescale 1ns/1ps
module spi_status_otp_sva
  import spi_status_pkg::*;
#(
  parameter int NUM_SECTORS = 4
) (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  // Watched ports
  input wire logic                   cs_n,
  input wire logic                   so_oe_n,
  input wire logic                   wp_n,
  input wire logic                   op_busy,
  input wire logic                   op_done,
  input wire logic                   op_fail,
  input wire logic                   reset_op,
  input wire logic [NUM_SECTORS-1:0] sector_prot,
  input wire logic                   cmd_valid,
  input wire logic                   glob_valid,
  input wire logic [7:0]             status_out
);
  logic [2:0] up_q;
  logic [2:0] wst_q;
  logic       wl_q;
  logic       rdy;
  function automatic logic [1:0] swp_sum(logic [NUM_SECTORS-1:0] p);
    return (&p) ? SWP_ALL : (|p) ? SWP_SOME : SWP_NONE;
  endfunction
  // Cycles since reset and since last protect pin change
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_q  <= 3'h0;
      wst_q <= 3'h0;
      wl_q  <= 1'b1;
    end else begin
      up_q  <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      wst_q <= (wp_n != wl_q) ? 3'h0 : (wst_q == 3'h7) ? wst_q : wst_q + 3'h1;
      wl_q  <= wp_n;
    end
  end
  assign rdy = (up_q == 3'h7);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_oe_idle_high: assert property (cs_n |-> so_oe_n)
    else $error("output enabled while deselected");
  a_busy_follows: assert property (rdy |-> status_out[ST_BUSY] == $past(op_busy))
    else $error("busy bit does not follow core");
  a_swp_summary: assert property (rdy |-> status_out[3:2] == swp_sum($past(sector_prot)))
    else $error("protection summary wrong");
  a_wpp_mirror: assert property (rdy && wst_q == 3'h7 |-> status_out[ST_WPP] == wl_q)
    else $error("protect pin bit wrong");
  a_err_update: assert property (op_done |-> ##2 status_out[ST_ERR] == $past(op_fail, 2))
    else $error("error flag not updated");
  a_err_quiet: assert property (rdy && !$past(op_done) && !$past(op_done, 2) |-> $stable(status_out[ST_ERR]))
    else $error("error flag changed without completion");
  a_cmd_clears_wel: assert property (cmd_valid |-> cs_n ##1 (!cmd_valid && !status_out[ST_WEL]))
    else $error("command pulse or latch clear wrong");
  a_glob_unlocked: assert property (glob_valid |-> !status_out[ST_LOCK])
    else $error("global request while locked");
  a_reset_keeps_lock: assert property (reset_op |-> ##1 $stable(status_out[ST_LOCK]) [*3] ##0 !status_out[ST_WEL])
    else $error("reset operation effect wrong");
endmodule
bind spi_status_otp spi_status_otp_sva #(.NUM_SECTORS(NUM_SECTORS)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n), .so_oe_n(so_oe_n), .wp_n(wp_n),
  .op_busy(op_busy), .op_done(op_done), .op_fail(op_fail), .reset_op(reset_op),
  .sector_prot(sector_prot), .cmd_valid(cmd_valid), .glob_valid(glob_valid),
  .status_out(status_out)
);

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Serial link
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  logic line;
  logic last_q;
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b0;
    last_q = 1'b0;
  end
  // Released line shows the inverse of the last driven bit
  always @(so_out or so_oe_n) if (!so_oe_n) last_q = so_out;
  assign line = so_oe_n ? ~last_q : so_out;
  // One frame, MSB first, 12 ns clock that stands still outside it
  task automatic xfer(input logic [79:0] tx, input int nbits, output logic [79:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = tx[nbits-1-i];
      #6;
      rx  = {rx[78:0], line};
      sck = 1'b1;
      #6;
      sck = 1'b0;
    end
    #3;
    cs_n = 1'b1;
    si   = ~si;
    #200;
  endtask
endmodule

// file: verification/spi_status_otp_bench.sv
`timescale 1ns/1ps
module spi_status_otp_bench
  import spi_status_pkg::*;
;
  function automatic logic [7:0] otp_byte(int i);
    return 8'(i * 29 + 7);
  endfunction
  function automatic logic [OTP_DEPTH*8-1:0] otp_img();
    for (int i = 0; i < OTP_DEPTH; i++) otp_img[i*8 +: 8] = otp_byte(i);
  endfunction
  localparam logic [OTP_DEPTH*8-1:0] OTP_PAT = otp_img();
  localparam logic [7:0]             WREN_OPCODE = 8'h06;
  localparam logic [7:0]             WRDI_OPCODE = 8'h04;
  localparam logic [7:0]             PROT_OPCODE = 8'h36;
  logic        sys_clk = 1'b0, rst_b = 1'b0, wp_n = 1'b1, op_busy = 1'b0;
  logic        op_done = 1'b0, op_fail = 1'b0, reset_op = 1'b0, hold_abort = 1'b0;
  logic [3:0]  sector_prot = 4'hf;
  wire         sck, cs_n, si;
  logic        so_out, so_oe_n, cmd_valid, glob_valid, e_lock = 0, e_err = 0, e_wel = 0;
  logic [7:0]  cmd_opcode, status_out, last_op;
  logic [3:0]  glob_bits;
  logic [79:0] rx;
  logic [31:0] a;
  logic [6:0]  ix;
  logic [15:0] got16, exp16;
  int          n_errors = 0, compares = 0, cyc = 0, n_cmd = 0, n_glob = 0;
  integer      seed = 53;
  always #10 sys_clk = ~sys_clk;
  spi_status_otp #(.OTP_INIT(OTP_PAT)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n), .wp_n(wp_n), .op_busy(op_busy), .op_done(op_done), .op_fail(op_fail),
    .reset_op(reset_op), .hold_abort(hold_abort), .sector_prot(sector_prot),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .glob_valid(glob_valid),
    .glob_bits(glob_bits), .status_out(status_out)
  );
  spi_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n));
  task stop_test;
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Pulse monitor and timeout
  always @(posedge sys_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_op = cmd_opcode;
    end
    if (glob_valid === 1'b1) n_glob++;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_st();
    return {e_lock, RSVD_VALUE, e_err, wp_n,
            (&sector_prot) ? SWP_ALL : (|sector_prot) ? SWP_SOME : SWP_NONE, e_wel, op_busy};
  endfunction
  task frame(input logic [79:0] tx, input int n);
    host_u.xfer(tx, n, rx);
  endtask
  task rd_st;
    frame(80'h05 << 8, 16);
    chk(rx[7:0], exp_st());
    chk(status_out, exp_st());
  endtask
  task wren;
    frame(80'(WREN_OPCODE), 8);
    e_wel = 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_st();
    fork
      host_u.xfer(80'h05 << 24, 32, rx);
      begin
        repeat (9) @(posedge sys_clk);
        op_busy <= 1'b1;
      end
    join
    chk(rx[23:16], exp_st() & 8'hfe);
    chk(rx[7:0], exp_st());
    @(posedge sys_clk) {op_busy, op_done, op_fail} <= 3'b011;
    @(posedge sys_clk) op_done <= 1'b0;
    e_err = 1'b1;
    rd_st();
    frame(80'h02_00_00_00, 32);
    chk(8'(n_cmd), 8'h0);
    rd_st();
    wren();
    frame(80'h00, 5);
    frame(80'hab, 8);
    rd_st();
    frame(80'h02_00_00_10, 32);
    e_wel = 1'b0;
    chk(8'(n_cmd), 8'h1);
    chk(last_op, 8'h02);
    wren();
    frame(80'(WRDI_OPCODE), 8);
    e_wel = 1'b0;
    rd_st();
    @(posedge sys_clk) {op_done, op_fail} <= 2'b10;
    @(posedge sys_clk) op_done <= 1'b0;
    e_err = 1'b0;
    rd_st();
    wren();
    frame(80'h01_bc, 16);
    {e_lock, e_wel} = 2'b10;
    chk({7'h0, glob_bits == 4'hf}, 8'h1);
    wren();
    frame(80'h01_bc, 16);
    e_wel = 1'b0;
    chk(8'(n_glob), 8'h1);
    rd_st();
    @(posedge sys_clk) wp_n <= 1'b0;
    wren();
    frame(80'h01_00, 16);
    e_wel = 1'b0;
    rd_st();
    wren();
    frame({PROT_OPCODE, 24'h0}, 32);
    e_wel = 1'b0;
    chk(8'(n_cmd), 8'h1);
    wren();
    @(posedge sys_clk) reset_op <= 1'b1;
    @(posedge sys_clk) reset_op <= 1'b0;
    e_wel = 1'b0;
    rd_st();
    wren();
    @(posedge sys_clk) hold_abort <= 1'b1;
    @(posedge sys_clk) hold_abort <= 1'b0;
    e_wel = 1'b0;
    @(posedge sys_clk) wp_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_st();
    wren();
    frame(80'h01_00, 16);
    {e_lock, e_wel} = 2'b00;
    rd_st();
    frame({8'h77, 24'hff_ff_fe, 16'h0, 24'h0}, 72);
    chk(rx[23:16], otp_byte(126));
    chk(rx[15:8], otp_byte(127));
    chk(rx[7:0], otp_byte(0));
    for (int k = 0; k < 4; k++) begin
      a = $random(seed);
      @(posedge sys_clk) sector_prot <= (k == 0) ? 4'h0 : a[11:8];
      frame(80'({8'h77, 16'h0, a[7:0], 16'h0, 16'h0}) >> (k * 3), 64 - k * 3);
      ix = a[6:0];
      got16 = rx[15:0] << (k * 3);
      exp16 = {otp_byte(ix), otp_byte(7'(ix + 7'h1))} & (16'hffff << (k * 3));
      chk(got16[15:8], exp16[15:8]);
      chk(got16[7:0], exp16[7:0]);
      chk({7'h0, so_oe_n}, 8'h1);
      rd_st();
    end
    stop_test();
  end
endmodule
